// File: common/psa_pkg.sv
package psa_pkg;
   // *****************************************************
   // Register indices on the serial management port
   // *****************************************************
   localparam logic [4:0] REG_MODE_STATUS = 5'h01; // port_mode_status
   localparam logic [4:0] REG_ID_HIGH = 5'h02; // vendor_id_high
   localparam logic [4:0] REG_ID_LOW = 5'h03; // vendor_id_low_model_rev
   localparam logic [4:0] REG_ADVERT = 5'h04; // local_ability_advert
   localparam logic [4:0] REG_PARTNER = 5'h05; // partner_ability
   localparam logic [4:0] REG_EXPANSION = 5'h06; // negotiation_expansion

   // *****************************************************
   // Management frame fields
   // *****************************************************
   localparam logic [1:0] OP_READ = 2'h2; // Read opcode
   localparam logic [1:0] OP_WRITE = 2'h1; // Write opcode
   localparam logic [3:0] HDR_LAST = 4'hb; // Opcode, port, register: 12 bits
   localparam logic [3:0] TA_LAST = 4'h1; // Two turnaround bits
   localparam logic [3:0] DATA_LAST = 4'hf; // Sixteen data bits

   // *****************************************************
   // Field layouts and reset values
   // *****************************************************
   localparam logic [15:0] STATUS_FIXED = 16'h79c9; // Capabilities, bits 7 and 6, bits 3 and 0
   localparam int STATUS_AN_DONE = 5; // Negotiation complete
   localparam int STATUS_FAR_FAULT = 4; // Far-end fault, latches high
   localparam int STATUS_LINK = 2; // Link up, latches low
   localparam int STATUS_JABBER = 1; // Jabber, latches high
   localparam logic [15:0] ADVERT_RESET = 16'h01e1; // Abilities on, selector 00001
   localparam logic [15:0] ADVERT_WMASK = 16'hbfff; // Bit 14 stays 0
   localparam logic [15:0] PARTNER_MASK = 16'hefff; // Bit 12 reads 0
   localparam logic [15:0] EXP_FIXED = 16'h0004; // Local next page able
   localparam int EXP_PD_FAULT = 4; // Parallel detection fault
   localparam int EXP_PARTNER_NP = 3; // Partner next page able
   localparam int EXP_PAGE_RX = 1; // Page received, latches low
   localparam int EXP_PARTNER_AN = 0; // Partner negotiation able

   // Live conditions from the link and negotiation logic
   typedef struct packed {
      logic an_complete;
      logic far_fault;
      logic link_up;
      logic jabber;
      logic pd_fault;
      logic page_rx;
      logic partner_np_able;
      logic partner_an_able;
      logic [15:0] partner_page;
   } psa_status_t;

   // Management frame receiver states
   typedef enum logic [2:0] {
      FRM_IDLE,
      FRM_START,
      FRM_HEADER,
      FRM_TURN,
      FRM_DATA
   } psa_mgmt_state_t;
endpackage : psa_pkg

// File: rtl/psa_regs.sv
// What this block does
// - Bits 15..9 fixed: 14..11 one, others zero
// - Bit 8 reads one: extended status
// - Preamble optional; frames without preamble accepted
// - Bits 0,3 one; bit 5 negotiation complete
// - Far-end fault latches high until read
// - Jabber latches high, link latches low
// - Register 2 carries identifier bits 3..18
// - Register 3: identifier, model, revision constants
// - Advert 15,13,12 writable; 14 reads zero
// - Advert pause bits writable, reset zero
// - Advert 9..0 writable; reset 0x01e1
// - Partner register mirrors received base page, bit 12 reads zero
// - Partner pause, abilities, selector reported
// - Parallel detection fault latches; 15..5 zero
// - Page received latches low, reset zero
// - Partner next-page and negotiation ability
// - Expansion bit 2 always one
module psa_regs #(
   parameter logic [4:0] PORT_ADDR = 5'h01, // Port address to answer
   parameter logic [15:0] VENDOR_HIGH = 16'h1234, // Arbitrary value
   parameter logic [5:0] VENDOR_LOW = 6'h15, // Arbitrary value
   parameter logic [5:0] MODEL_NUM = 6'h0a, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h3 // Arbitrary value
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic serial_mgmt_clk,
   input wire logic serial_mgmt_din,
   output logic serial_mgmt_dout,
   output logic serial_mgmt_oe,
   input wire psa_pkg::psa_status_t live_status,
   output logic [15:0] advert
);
   // *****************************************************
   // Input synchronisers
   // *****************************************************
   logic [1:0] mdc_sync; // Management clock pin
   logic [1:0] mdio_sync; // Management data pin
   logic mdc_prev; // Last synchronised clock level
   psa_pkg::psa_status_t sts_meta; // First stage, read only by sts
   psa_pkg::psa_status_t sts; // Usable status

   // Pins pass two flops before any edge logic
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mdc_sync <= 2'h0;
         mdio_sync <= 2'h3;
         mdc_prev <= 1'b0;
      end else begin
         mdc_sync <= {mdc_sync[0], serial_mgmt_clk};
         mdio_sync <= {mdio_sync[0], serial_mgmt_din};
         mdc_prev <= mdc_sync[1];
      end
   end

   // Status words are quasi-static, so a plain double flop suffices
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sts_meta <= '0;
         sts <= '0;
      end else begin
         sts_meta <= live_status;
         sts <= sts_meta;
      end
   end

   logic mdc_rise; // Controller samples here
   logic mdc_fall; // We change the line here
   logic mdio_bit; // Synchronised data
   assign mdc_rise = mdc_sync[1] & ~mdc_prev;
   assign mdc_fall = ~mdc_sync[1] & mdc_prev;
   assign mdio_bit = mdio_sync[1];

   // *****************************************************
   // Frame receiver
   // *****************************************************
   psa_pkg::psa_mgmt_state_t state; // Frame position
   logic [3:0] cnt; // Bit within field
   logic [11:0] hdr; // Opcode, port, register
   logic [15:0] wdata; // Write data shift
   logic [15:0] rshift; // Read data shift
   logic is_read; // Frame is a read for us
   logic is_write; // Frame is a write for us
   logic hdr_done; // Last header bit seen
   logic [11:0] hdr_full; // Header including this bit
   logic read_take; // Snapshot and refresh strobe
   logic write_take; // Commit strobe
   logic [15:0] rd_value; // Selected register value

   localparam logic [3:0] TA_LAST_C = psa_pkg::TA_LAST; // Second turnaround bit

   assign hdr_full = {hdr[10:0], mdio_bit};
   assign hdr_done = mdc_rise && state == psa_pkg::FRM_HEADER && cnt == psa_pkg::HDR_LAST;
   assign read_take = hdr_done && hdr_full[11:10] == psa_pkg::OP_READ
                      && hdr_full[9:5] == PORT_ADDR;
   assign write_take = mdc_rise && state == psa_pkg::FRM_DATA && is_write
                       && cnt == psa_pkg::DATA_LAST;

   // Preamble ones are skipped, so a frame may open on its start bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= psa_pkg::FRM_IDLE;
         cnt <= 4'h0;
         hdr <= 12'h000;
         wdata <= 16'h0000;
         is_read <= 1'b0;
         is_write <= 1'b0;
      end else if (mdc_rise) begin
         case (state)
            psa_pkg::FRM_IDLE: begin
               // A zero after idle ones is the first start bit
               if (!mdio_bit) begin
                  state <= psa_pkg::FRM_START;
               end
            end
            psa_pkg::FRM_START: begin
               // Start must be 01, else drop back
               state <= mdio_bit ? psa_pkg::FRM_HEADER : psa_pkg::FRM_IDLE;
               cnt <= 4'h0;
            end
            psa_pkg::FRM_HEADER: begin
               hdr <= hdr_full;
               cnt <= cnt + 4'h1;
               if (cnt == psa_pkg::HDR_LAST) begin
                  state <= psa_pkg::FRM_TURN;
                  cnt <= 4'h0;
                  is_read <= read_take;
                  is_write <= hdr_full[11:10] == psa_pkg::OP_WRITE
                              && hdr_full[9:5] == PORT_ADDR;
               end
            end
            psa_pkg::FRM_TURN: begin
               cnt <= cnt + 4'h1;
               if (cnt == psa_pkg::TA_LAST) begin
                  state <= psa_pkg::FRM_DATA;
                  cnt <= 4'h0;
               end
            end
            psa_pkg::FRM_DATA: begin
               wdata <= {wdata[14:0], mdio_bit};
               cnt <= cnt + 4'h1;
               if (cnt == psa_pkg::DATA_LAST) begin
                  state <= psa_pkg::FRM_IDLE;
               end
            end
            default: begin
               state <= psa_pkg::FRM_IDLE;
            end
         endcase
      end
   end

   // Read data leaves on falling edges; released once the frame ends
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rshift <= 16'h0000;
         serial_mgmt_dout <= 1'b1;
         serial_mgmt_oe <= 1'b0;
      end else if (read_take) begin
         rshift <= rd_value;
      end else if (mdc_fall) begin
         if (state == psa_pkg::FRM_TURN && is_read && cnt == TA_LAST_C) begin
            serial_mgmt_oe <= 1'b1;
            serial_mgmt_dout <= 1'b0;
         end else if (state == psa_pkg::FRM_DATA && is_read) begin
            serial_mgmt_dout <= rshift[15];
            rshift <= {rshift[14:0], 1'b0};
         end else begin
            serial_mgmt_oe <= 1'b0;
            serial_mgmt_dout <= 1'b1;
         end
      end
   end

   // *****************************************************
   // Latched status bits
   // *****************************************************
   logic rd_status; // Mode status was read
   logic rd_exp; // Expansion was read
   logic far_fault; // Latched high
   logic jabber; // Latched high
   logic link_up; // Latched low
   logic pd_fault; // Latched high
   logic page_rx; // Latched low
   assign rd_status = read_take && hdr_full[4:0] == psa_pkg::REG_MODE_STATUS;
   assign rd_exp = read_take && hdr_full[4:0] == psa_pkg::REG_EXPANSION;

   // A read reloads from live, so an event in that cycle still sticks
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         far_fault <= 1'b0;
         jabber <= 1'b0;
         link_up <= 1'b0;
      end else if (rd_status) begin
         far_fault <= sts.far_fault;
         jabber <= sts.jabber;
         link_up <= sts.link_up;
      end else begin
         far_fault <= far_fault | sts.far_fault;
         jabber <= jabber | sts.jabber;
         link_up <= link_up & sts.link_up;
      end
   end

   // Expansion latches behave the same way on their own read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pd_fault <= 1'b0;
         page_rx <= 1'b0;
      end else if (rd_exp) begin
         pd_fault <= sts.pd_fault;
         page_rx <= sts.page_rx;
      end else begin
         pd_fault <= pd_fault | sts.pd_fault;
         page_rx <= page_rx & sts.page_rx;
      end
   end

   // *****************************************************
   // Advertisement and read mux
   // *****************************************************
   // Only the advertisement accepts writes; others drop them
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         advert <= psa_pkg::ADVERT_RESET;
      end else if (write_take && hdr[4:0] == psa_pkg::REG_ADVERT) begin
         // Bit 14 masked off
         advert <= {wdata[14:0], mdio_bit} & psa_pkg::ADVERT_WMASK;
      end
   end

   logic [15:0] status_val; // Mode status view
   logic [15:0] exp_val; // Expansion view
   always_comb begin
      status_val = psa_pkg::STATUS_FIXED;
      status_val[psa_pkg::STATUS_AN_DONE] = sts.an_complete;
      status_val[psa_pkg::STATUS_FAR_FAULT] = far_fault;
      status_val[psa_pkg::STATUS_LINK] = link_up;
      status_val[psa_pkg::STATUS_JABBER] = jabber;
      exp_val = psa_pkg::EXP_FIXED;
      exp_val[psa_pkg::EXP_PD_FAULT] = pd_fault;
      exp_val[psa_pkg::EXP_PARTNER_NP] = sts.partner_np_able;
      exp_val[psa_pkg::EXP_PAGE_RX] = page_rx;
      exp_val[psa_pkg::EXP_PARTNER_AN] = sts.partner_an_able;
   end

   // Unmapped addresses read as zero
   always_comb begin
      case (hdr_full[4:0])
         psa_pkg::REG_MODE_STATUS: rd_value = status_val;
         psa_pkg::REG_ID_HIGH: rd_value = VENDOR_HIGH;
         psa_pkg::REG_ID_LOW: rd_value = {VENDOR_LOW, MODEL_NUM, REVISION};
         psa_pkg::REG_ADVERT: rd_value = advert;
         psa_pkg::REG_PARTNER: begin
            rd_value = sts.partner_page & psa_pkg::PARTNER_MASK;
         end
         psa_pkg::REG_EXPANSION: rd_value = exp_val;
         default: rd_value = 16'h0000;
      endcase
   end

   // *****************************************************
   // Assertions
   // *****************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_fixed_bits;
      (status_val & 16'hffc9) == psa_pkg::STATUS_FIXED;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

   // Two edges after reset the status flops still hold zero, so skip them
   property p_an_done;
      $past(rst_n) && $past(rst_n, 2)
      |-> status_val[psa_pkg::STATUS_AN_DONE] == $past(live_status.an_complete, 2);
   endproperty
   a_an_done: assert property (p_an_done) else $error("an complete not tracked");

   property p_fault_hold;
      far_fault && !rd_status |=> far_fault;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("far fault lost");

   property p_link_low;
      !link_up && !rd_status |=> !link_up;
   endproperty
   a_link_low: assert property (p_link_low) else $error("link low not held");

   property p_pd_hold;
      pd_fault && !rd_exp |=> pd_fault;
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("pd fault lost");

   property p_exp_const;
      exp_val[2] && exp_val[15:5] == 11'h000;
   endproperty
   a_exp_const: assert property (p_exp_const) else $error("expansion constants wrong");

   property p_adv_write;
      write_take && hdr[4:0] == psa_pkg::REG_ADVERT
      |=> advert == ($past({wdata[14:0], mdio_bit}) & psa_pkg::ADVERT_WMASK);
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("advert write wrong");

   property p_sync;
      $past(rst_n) && $past(rst_n, 2) |-> sts.link_up == $past(live_status.link_up, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("status not two-stage");

   sequence s_turn_drive;
      mdc_fall && state == psa_pkg::FRM_TURN && is_read && cnt == TA_LAST_C;
   endsequence
   sequence s_drive_zero;
      serial_mgmt_oe && !serial_mgmt_dout;
   endsequence
   property p_read_turn;
      s_turn_drive |=> s_drive_zero;
   endproperty
   a_read_turn: assert property (p_read_turn) else $error("turnaround not driven");
endmodule : psa_regs

// File: test/psa_mgmt_host.sv
// Station controller model: drives management frames, MSB first
module psa_mgmt_host #(
   parameter logic [4:0] PORT = 5'h01 // Port address used in frames
) (
   input wire logic clock,
   output logic mgmt_clk,
   output logic mgmt_bit,
   output logic mgmt_en,
   input wire logic mgmt_wire
);
   timeunit 1ns;
   timeprecision 100ps;
   // Clocks per half period; the device needs more than 2
   localparam int HALF = 8;

   // Idle: clock parked low, line released
   initial begin
      mgmt_clk = 1'b0;
      mgmt_bit = 1'b1;
      mgmt_en = 1'b0;
   end

   // *****************
   // Frame tasks
   // *****************
   // Step n system clocks, landing just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   // Data is launched while the clock is low, sampled at its rise
   task automatic frame(input logic [1:0] op, input logic [4:0] ra,
         input logic [15:0] wd, input bit pre, output logic [15:0] rd);
      logic [31:0] seq;
      int n;
      // Reads leave turnaround and data to the device
      seq = {2'b01, op, PORT, ra, (op == psa_pkg::OP_WRITE) ? {2'b10, wd} : 18'h3ffff};
      n = pre ? 64 : 32; // Preamble is optional
      rd = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         mgmt_clk = 1'b0;
         mgmt_en = (i > 17) || (op == psa_pkg::OP_WRITE);
         mgmt_bit = (i > 31) ? 1'b1 : seq[i];
         tick(HALF);
         mgmt_clk = 1'b1;
         if (i < 16) begin
            rd[i] = mgmt_wire;
         end
         tick(HALF);
      end
      // Release; clock stands still between frames
      mgmt_clk = 1'b0;
      mgmt_en = 1'b0;
      mgmt_bit = 1'b1;
      tick(2 * HALF);
   endtask : frame

   // Read first so reserved bits go back as they were read
   task automatic modify(input logic [4:0] ra, input logic [15:0] set_m);
      logic [15:0] v;
      frame(psa_pkg::OP_READ, ra, 16'h0000, 1'b1, v);
      frame(psa_pkg::OP_WRITE, ra, v | set_m, 1'b1, v);
   endtask : modify
endmodule : psa_mgmt_host

// File: test/psa_regs_bench.sv
module psa_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] VH = 16'h2c4e; // Arbitrary value
   localparam logic [5:0] VL = 6'h2b; // Arbitrary value
   localparam logic [5:0] MN = 6'h11; // Arbitrary value
   localparam logic [3:0] RV = 4'h6; // Arbitrary value
   logic clock;
   logic rst_n;
   logic mgmt_clk; // From the controller model
   logic host_bit;
   logic host_en;
   logic dout;
   logic oe;
   logic mdio; // Resolved line level
   psa_pkg::psa_status_t live;
   logic [15:0] advert;
   int errors;
   int num_checks;

   // Line has a pull-up: released means high
   assign mdio = oe ? dout : (host_en ? host_bit : 1'b1);

   psa_regs #(.VENDOR_HIGH(VH), .VENDOR_LOW(VL), .MODEL_NUM(MN), .REVISION(RV))
   psa_regs_i (.clock(clock), .rst_n(rst_n), .serial_mgmt_clk(mgmt_clk),
      .serial_mgmt_din(mdio), .serial_mgmt_dout(dout), .serial_mgmt_oe(oe),
      .live_status(live), .advert(advert));

   psa_mgmt_host psa_mgmt_host_i (.clock(clock), .mgmt_clk(mgmt_clk), .mgmt_bit(host_bit),
      .mgmt_en(host_en), .mgmt_wire(mdio));

   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // *****************
   // Helpers
   // *****************
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input string what, input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] v;
      psa_mgmt_host_i.frame(psa_pkg::OP_READ, ra, 16'h0000, 1'b1, v);
      check(what, v, exp);
   endtask : rd_chk

   task automatic wr(input logic [4:0] ra, input logic [15:0] d, input bit pre);
      logic [15:0] v;
      psa_mgmt_host_i.frame(psa_pkg::OP_WRITE, ra, d, pre, v);
   endtask : wr

   // *****************
   // Scenarios
   // *****************
   task automatic test_reset;
      check("advert", advert, 16'h01e1);
      rd_chk("status", 5'h01, 16'h79c9);
      rd_chk("id_high", 5'h02, VH);
      rd_chk("id_low", 5'h03, {VL, MN, RV});
      rd_chk("advert_reg", 5'h04, 16'h01e1);
      rd_chk("partner", 5'h05, 16'h0000);
      rd_chk("expansion", 5'h06, 16'h0004);
      rd_chk("unmapped", 5'h07, 16'h0000);
   endtask : test_reset

   // Short pulses must still be caught by the latches
   task automatic test_status;
      live.link_up = 1'b1;
      live.an_complete = 1'b1;
      tick(4);
      rd_chk("status_link", 5'h01, 16'h79e9);
      rd_chk("status_live", 5'h01, 16'h79ed);
      live.far_fault = 1'b1;
      live.jabber = 1'b1;
      live.link_up = 1'b0;
      tick(5);
      live.far_fault = 1'b0;
      live.jabber = 1'b0;
      live.link_up = 1'b1;
      tick(5);
      rd_chk("status_latched", 5'h01, 16'h79fb);
      rd_chk("status_clear", 5'h01, 16'h79ed);
      live.an_complete = 1'b0;
      tick(4);
      rd_chk("status_an_off", 5'h01, 16'h79cd);
   endtask : test_status

   task automatic test_expansion;
      live.page_rx = 1'b1;
      live.partner_np_able = 1'b1;
      live.partner_an_able = 1'b1;
      live.partner_page = 16'hffff;
      tick(4);
      rd_chk("partner_all", 5'h05, 16'hefff);
      rd_chk("exp_first", 5'h06, 16'h000d);
      rd_chk("exp_live", 5'h06, 16'h000f);
      live.pd_fault = 1'b1;
      live.page_rx = 1'b0;
      tick(5);
      live.pd_fault = 1'b0;
      live.page_rx = 1'b1;
      tick(5);
      rd_chk("exp_latched", 5'h06, 16'h001d);
      rd_chk("exp_clear", 5'h06, 16'h000f);
   endtask : test_expansion

   // Writes, with and without preamble, and writes to read-only places
   task automatic test_write;
      wr(5'h04, 16'hffff, 1'b1);
      check("advert_port", advert, 16'hbfff);
      rd_chk("advert_all", 5'h04, 16'hbfff);
      wr(5'h04, 16'h0000, 1'b0);
      rd_chk("advert_zero", 5'h04, 16'h0000);
      psa_mgmt_host_i.modify(5'h04, 16'h0c00);
      rd_chk("advert_pause", 5'h04, 16'h0c00);
      for (int r = 1; r < 8; r++) begin
         if (r != 4) begin
            wr(5'(r), 16'h0000, 1'b1);
         end
      end
      check("advert_kept", advert, 16'h0c00);
      rd_chk("id_high_ro", 5'h02, VH);
      rd_chk("id_low_ro", 5'h03, {VL, MN, RV});
      rd_chk("partner_ro", 5'h05, 16'hefff);
      rd_chk("exp_ro", 5'h06, 16'h000f);
   endtask : test_write

   // Reset in mid-run restores the advertisement, the latches and the line
   task automatic test_rerst;
      rst_n = 1'b0;
      tick(2);
      check("advert_rerst", advert, 16'h01e1);
      check("line_rerst", {14'h0, oe, dout}, 16'h0001);
      rst_n = 1'b1;
      tick(4);
      rd_chk("status_rerst", 5'h01, 16'h79c9);
      rd_chk("exp_rerst", 5'h06, 16'h000d);
      rd_chk("advert_reg_rerst", 5'h04, 16'h01e1);
   endtask : test_rerst

   task automatic end_sim;
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      live = '0;
      tick(2);
      rst_n = 1'b1;
      tick(4);
      test_reset();
      test_status();
      test_expansion();
      test_write();
      test_rerst();
      end_sim();
   end

   // Watchdog: about twice the expected run
   initial begin
      #800000;
      errors++;
      end_sim();
   end
endmodule : psa_regs_bench
